/* File: pkg/pwrctl_consts.svh */
// Timing and layout constants for the power control pin logic.
// Counts are in ticks of the 32.768 kHz oscillator unless said otherwise.
`ifndef PWRCTL_CONSTS_SVH
`define PWRCTL_CONSTS_SVH
`define CLK_PERIOD_NS 40
`define OSC_HZ 32768
`define GRST_HOLD_S 12
`define GRST_HOLD_TICKS (`GRST_HOLD_S * `OSC_HZ)
`define QUAL_TICKS 3
`define STARTUP_TICKS 8'h10
`define WDOG_TICKS 8'h40
`define GRST_OFF_TICKS 8'h08
`define KEY_RST_IDX 2
`define SYNC_RESET_VAL 1'b1
`endif

/* File: pkg/pwrctl_pkg.sv */
// Types shared by the power control pin logic.
// Assumes pin levels arrive already converted to logic levels.
package pwrctl_pkg;
   typedef enum logic [2:0] {st_off, st_start, st_wdog, st_on, st_standby, st_lpoff, st_grst} pwr_state_t;
   typedef enum logic [1:0] {op_normal, op_usb_lpb, op_test} op_mode_t;
   typedef struct packed {
      logic keepalive_input;
      logic host_sleep_request;
      logic peripheral_sleep_request;
      logic [2:0] power_key_inputs;
      logic osc32k;
      logic cs_pin;
      logic mosi_pin;
      logic sclk_pin;
      logic sda_pin;
   } pin_in_t;
   typedef struct packed {
      logic startup_profile_strap_a;
      logic startup_profile_strap_b;
      logic mode_at_digital_core_rail;
      logic mode_at_analog_core_rail;
      logic id_at_ground;
      logic id_at_factory;
   } strap_in_t;
   typedef struct packed {
      logic global_reset_enable_bit;
      logic grst_active_high;
      logic host_sleep_pol;
      logic peripheral_sleep_pol;
      logic cold_start_on_wdog;
      logic lpoff_host_clk_on;
      logic hold_host_reset;
      logic hold_peripheral_reset;
      logic otg_bus_input_switch;
      logic lp_off_req;
   } cfg_t;
   typedef struct packed {
      pwr_state_t state;
      logic bus_is_spi;
      logic i2c_addr_lsb;
      op_mode_t op_mode;
      logic [1:0] startup_profile;
      logic id_floating;
      logic id_grounded;
      logic id_factory;
      logic standby_event;
   } status_t;
endpackage

/* File: src/power_control_pin_logic.sv */
// Power control pin logic: modes, standby, global reset, straps, slow clocks, resets.
// Assumes one 25 MHz clock; all pin levels are asynchronous and synchronised here.
`timescale 1ns/1ps
`include "pwrctl_consts.svh"
module power_control_pin_logic #(
   parameter int GRST_TICKS = `GRST_HOLD_TICKS,
   parameter int IRQ_W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Pins and straps
   input wire pwrctl_pkg::pin_in_t pins_i,
   input wire pwrctl_pkg::strap_in_t straps_i,
   // Configuration and events
   input wire pwrctl_pkg::cfg_t cfg_i,
   input wire logic [IRQ_W-1:0] irq_event_i,
   input wire logic [IRQ_W-1:0] irq_mask_i,
   // Serial engine side
   input wire logic spi_miso_i,
   input wire logic sda_drive_low_i,
   output logic serial_clk_o,
   output logic serial_cs_o,
   output logic serial_din_o,
   output logic miso_o,
   output logic miso_oe_o,
   // Status and control outputs
   output pwrctl_pkg::status_t status_o,
   output logic int_o,
   output logic host_slow_clock_out_o,
   output logic peripheral_slow_clock_out_o,
   output logic host_reset_out_n_o,
   output logic peripheral_reset_out_n_o,
   output logic charger_disable_o,
   output logic regs_default_o,
   output logic usb_switch_close_o
);
   import pwrctl_pkg::*;

   localparam int SW = $bits(pin_in_t) + $bits(strap_in_t);
   localparam int HW = $clog2(GRST_TICKS + 2);
   localparam int QUAL_M1 = `QUAL_TICKS - 1;

   // Pin synchroniser group
   logic [SW-1:0] s1_ff, s2_ff, s3_ff, flt_ff, nxt_flt;
   pin_in_t pin;
   strap_in_t strap;

   always_comb
   begin
      // Level moves only once the last two stages agree
      nxt_flt = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & flt_ff);
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         s1_ff <= {SW{`SYNC_RESET_VAL}};
         s2_ff <= {SW{`SYNC_RESET_VAL}};
         s3_ff <= {SW{`SYNC_RESET_VAL}};
         flt_ff <= {SW{`SYNC_RESET_VAL}};
      end
      else
      begin
         s1_ff <= {pins_i, straps_i};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         flt_ff <= nxt_flt;
      end
   end

   assign {pin, strap} = flt_ff;

   // Control group
   pwr_state_t state_ff, nxt_state;
   logic [7:0] tmr_ff, nxt_tmr;
   logic [HW-1:0] hold_ff, nxt_hold;
   logic [1:0] qual_ff, nxt_qual;
   logic stby_ff, nxt_stby, osc_d_ff, key3_d_ff;
   logic bus_spi_ff, nxt_bus_spi, addr_ff, nxt_addr;
   op_mode_t op_ff, nxt_op;
   logic [1:0] prof_ff, nxt_prof;
   logic int_ff, nxt_int, hclk_ff, nxt_hclk, pclk_ff, nxt_pclk;
   logic hrst_ff, nxt_hrst, prst_ff, nxt_prst, chg_ff, nxt_chg, def_ff, usb_ff;
   logic sclk_ff, cs_ff, din_ff, miso_ff, oe_ff;
   logic nxt_sclk, nxt_cs, nxt_din, nxt_miso, nxt_oe;
   logic tick, key_on, key3, both, grst_en, grst_fire, in_on, latch_now;

   always_comb
   begin
      tick = pin.osc32k & ~osc_d_ff;
      key_on = ~&pin.power_key_inputs;
      key3 = pin.power_key_inputs[`KEY_RST_IDX];
      in_on = (state_ff == st_on) || (state_ff == st_standby);
      both = (pin.host_sleep_request == cfg_i.host_sleep_pol) &&
             (pin.peripheral_sleep_request == cfg_i.peripheral_sleep_pol);
      grst_en = cfg_i.grst_active_high ? cfg_i.global_reset_enable_bit
                                       : ~cfg_i.global_reset_enable_bit;
      // Release edge after a hold past the limit; shorter holds fall through as a plain key
      grst_fire = key3 && !key3_d_ff && (hold_ff > HW'(GRST_TICKS)) && grst_en;

      // Hold counter restarts whenever the key is up
      nxt_hold = hold_ff;
      if (key3)
         nxt_hold = '0;
      else if (tick && hold_ff <= HW'(GRST_TICKS))
         nxt_hold = hold_ff + HW'(1);

      // Standby qualification; forced idle outside On so start-up never sees it
      nxt_stby = stby_ff;
      nxt_qual = '0;
      if (!in_on)
         nxt_stby = 1'b0;
      else if (both != stby_ff)
      begin
         nxt_qual = qual_ff;
         if (tick)
         begin
            if (qual_ff == 2'(QUAL_M1))
            begin
               nxt_stby = both;
               nxt_qual = '0;
            end
            else
               nxt_qual = qual_ff + 2'h1;
         end
      end

      nxt_state = state_ff;
      if (grst_fire && state_ff != st_grst)
         nxt_state = st_grst;
      else
      begin
         unique case (state_ff)
            st_off:
               if (key_on)
                  nxt_state = st_start;
            st_start:
               if (tmr_ff == `STARTUP_TICKS)
                  nxt_state = st_wdog;
            st_wdog:
               if (pin.keepalive_input)
                  nxt_state = st_on;
               else if (tmr_ff == `WDOG_TICKS)
                  nxt_state = st_off;
            st_on, st_standby:
               if (!pin.keepalive_input)
                  nxt_state = cfg_i.cold_start_on_wdog ? st_start : st_off;
               else if (state_ff == st_on && cfg_i.lp_off_req)
                  nxt_state = st_lpoff;
               else if (state_ff == st_on && stby_ff)
                  nxt_state = st_standby;
               else if (state_ff == st_standby && !stby_ff)
                  nxt_state = st_on;
            st_lpoff:
               if (key_on)
                  nxt_state = st_wdog;
            st_grst:
               if (tmr_ff == `GRST_OFF_TICKS)
                  nxt_state = st_start;
         endcase
      end
      nxt_tmr = (nxt_state != state_ff) ? 8'h00 : (tick ? tmr_ff + 8'h01 : tmr_ff);

      // Straps are caught on every entry into start-up
      latch_now = (nxt_state == st_start) && (state_ff != st_start);
      nxt_bus_spi = latch_now ? ~pin.cs_pin : bus_spi_ff;
      nxt_addr = latch_now ? pin.mosi_pin : addr_ff;
      nxt_prof = latch_now ? {strap.startup_profile_strap_b, strap.startup_profile_strap_a} : prof_ff;
      nxt_op = op_ff;
      if (latch_now)
         nxt_op = strap.mode_at_analog_core_rail ? op_test :
                  (strap.mode_at_digital_core_rail ? op_usb_lpb : op_normal);

      nxt_int = |(irq_event_i & ~irq_mask_i);
      nxt_hclk = pin.osc32k && !(state_ff inside {st_off, st_grst}) &&
                 (state_ff != st_lpoff || cfg_i.lpoff_host_clk_on);
      nxt_pclk = pin.osc32k && (state_ff inside {st_start, st_wdog, st_on});
      nxt_hrst = in_on && !cfg_i.hold_host_reset;
      nxt_prst = in_on && !cfg_i.hold_peripheral_reset;
      nxt_chg = (nxt_state == st_grst);

      // Serial pin routing; in I2C mode chip select is dead and SDA is open drain
      nxt_sclk = pin.sclk_pin;
      nxt_cs = bus_spi_ff & pin.cs_pin;
      nxt_din = bus_spi_ff ? pin.mosi_pin : pin.sda_pin;
      nxt_miso = bus_spi_ff ? spi_miso_i : 1'b0;
      nxt_oe = bus_spi_ff ? pin.cs_pin : sda_drive_low_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state_ff <= st_off;
         tmr_ff <= 8'h00;
         hold_ff <= '0;
         qual_ff <= 2'h0;
         stby_ff <= 1'b0;
         // Idle level of the filtered pin, so no false tick follows reset
         osc_d_ff <= `SYNC_RESET_VAL;
         key3_d_ff <= 1'b1;
         bus_spi_ff <= 1'b1;
         addr_ff <= 1'b0;
         op_ff <= op_normal;
         prof_ff <= 2'h0;
         int_ff <= 1'b0;
         hclk_ff <= 1'b0;
         pclk_ff <= 1'b0;
         hrst_ff <= 1'b0;
         prst_ff <= 1'b0;
         chg_ff <= 1'b0;
         def_ff <= 1'b0;
         usb_ff <= 1'b0;
         sclk_ff <= 1'b0;
         cs_ff <= 1'b0;
         din_ff <= 1'b0;
         miso_ff <= 1'b0;
         oe_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         tmr_ff <= nxt_tmr;
         hold_ff <= nxt_hold;
         qual_ff <= nxt_qual;
         stby_ff <= nxt_stby;
         osc_d_ff <= pin.osc32k;
         key3_d_ff <= key3;
         bus_spi_ff <= nxt_bus_spi;
         addr_ff <= nxt_addr;
         op_ff <= nxt_op;
         prof_ff <= nxt_prof;
         int_ff <= nxt_int;
         hclk_ff <= nxt_hclk;
         pclk_ff <= nxt_pclk;
         hrst_ff <= nxt_hrst;
         prst_ff <= nxt_prst;
         chg_ff <= nxt_chg;
         def_ff <= grst_fire;
         usb_ff <= cfg_i.otg_bus_input_switch;
         sclk_ff <= nxt_sclk;
         cs_ff <= nxt_cs;
         din_ff <= nxt_din;
         miso_ff <= nxt_miso;
         oe_ff <= nxt_oe;
      end
   end

   always_comb
   begin
      status_o.state = state_ff;
      status_o.bus_is_spi = bus_spi_ff;
      status_o.i2c_addr_lsb = addr_ff;
      status_o.op_mode = op_ff;
      status_o.startup_profile = prof_ff;
      // Both comparators quiet means nothing pulls the id pin
      status_o.id_floating = ~strap.id_at_ground & ~strap.id_at_factory;
      status_o.id_grounded = strap.id_at_ground;
      status_o.id_factory = strap.id_at_factory;
      status_o.standby_event = stby_ff;
   end

   assign int_o = int_ff;
   assign host_slow_clock_out_o = hclk_ff;
   assign peripheral_slow_clock_out_o = pclk_ff;
   assign host_reset_out_n_o = hrst_ff;
   assign peripheral_reset_out_n_o = prst_ff;
   assign charger_disable_o = chg_ff;
   assign regs_default_o = def_ff;
   assign usb_switch_close_o = usb_ff;
   assign serial_clk_o = sclk_ff;
   assign serial_cs_o = cs_ff;
   assign serial_din_o = din_ff;
   assign miso_o = miso_ff;
   assign miso_oe_o = oe_ff;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence long_release_s;
      grst_fire && state_ff != st_grst;
   endsequence
   sequence grst_entry_s;
      state_ff == st_grst && charger_disable_o && regs_default_o;
   endsequence

   wd_drop_a: assert property (in_on && !pin.keepalive_input && !grst_fire |=> state_ff inside {st_off, st_start})
      else $error("On held without keepalive");
   stby_entry_a: assert property (state_ff == st_on ##1 state_ff == st_standby
      |-> stby_ff && $past(stby_ff))
      else $error("Standby without qualified event");
   stby_pol_a: assert property ($rose(stby_ff) |-> $past(both) && $past(tick))
      else $error("Standby event ignores polarity");
   qual_delay_a: assert property ($rose(stby_ff) |-> $past(qual_ff) == 2'(QUAL_M1))
      else $error("Standby qualified too early");
   stby_ignored_a: assert property (state_ff inside {st_start, st_wdog} |=> state_ff != st_standby && !stby_ff)
      else $error("Sleep request acted outside On");
   int_out_a: assert property (|(irq_event_i & ~irq_mask_i) |=> int_o)
      else $error("Interrupt not raised");
   int_idle_a: assert property (!(|(irq_event_i & ~irq_mask_i)) |=> !int_o)
      else $error("Interrupt raised with nothing pending");
   key_on_a: assert property (state_ff == st_off && key_on && !grst_fire |=> state_ff == st_start)
      else $error("Power key did not turn on");
   grst_seq_a: assert property (long_release_s |=> grst_entry_s)
      else $error("Global reset not performed");
   short_press_a: assert property (key3 && !key3_d_ff && hold_ff <= HW'(GRST_TICKS) && state_ff != st_grst
      |=> state_ff != st_grst)
      else $error("Short press caused global reset");
   strap_latch_a: assert property (state_ff == st_off && key_on && !grst_fire
      |=> bus_spi_ff == !$past(pin.cs_pin) && addr_ff == $past(pin.mosi_pin))
      else $error("Bus mode strap not latched");
   i2c_sda_a: assert property (!bus_spi_ff && !latch_now |=> miso_oe_o == $past(sda_drive_low_i) && !miso_o && !serial_cs_o)
      else $error("I2C pin routing wrong");
   host_rst_a: assert property (!in_on |=> !host_reset_out_n_o && !peripheral_reset_out_n_o)
      else $error("Reset released outside On");
   usb_sw_a: assert property (cfg_i.otg_bus_input_switch |=> usb_switch_close_o)
      else $error("OTG switch not closed");
endmodule

/* File: verification/host_side_model.sv */
// Behavioural host processor: slow oscillator, keepalive, host sleep request, chip select.
// Assumes the bench commands the levels; the oscillator is sped up so that the run stays short.
`timescale 1ns/1ps
module host_side_model #(
   parameter int OSC_HALF = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Commands from the bench
   input wire logic alive_i,
   input wire logic sleep_i,
   input wire logic spi_i,
   // Pin levels
   output logic osc_o,
   output logic keepalive_o,
   output logic host_sleep_o,
   output logic cs_o
);
   int cnt;

   initial
   begin
      osc_o = 1'b0;
      cnt = 0;
   end

   // Oscillator runs free, also through reset, like the real crystal
   always @(posedge clk_i)
   begin
      if (cnt == OSC_HALF - 1)
      begin
         cnt <= 0;
         osc_o <= ~osc_o;
      end
      else
         cnt <= cnt + 1;
   end

   assign keepalive_o = alive_i;
   assign host_sleep_o = sleep_i;
   // Unpowered host leaves the select line pulled low through turn-on while spi_i is set, and high while it is clear
   assign cs_o = ~spi_i;
endmodule

/* File: verification/power_control_pin_logic_tb_top.sv */
// Self-checking bench for the power control pin logic.
// Assumes a 25 MHz clock and the sped-up oscillator of the host model.
`timescale 1ns/1ps
module power_control_pin_logic_tb_top;
   import pwrctl_pkg::*;
   localparam int TICK = 32;
   localparam int GRST = 20;
   logic clk_i, reset_i, alive, hsleep, spi, psleep, mosi, sclk, sda, miso, sda_low;
   logic osc, ka, hs, cs, s_clk, s_cs, s_din, miso_d, miso_oe, int_o, hclk, pclk, hrst_n, prst_n, chg, def, usb_sw;
   logic [2:0] keys;
   logic [15:0] irq_ev, irq_mask;
   pin_in_t pins;
   strap_in_t straps;
   cfg_t cfg;
   status_t status;
   int fails, total_checks, def_pulses, pclk_edges, hclk_edges;

   assign pins = '{keepalive_input: ka, host_sleep_request: hs, peripheral_sleep_request: psleep,
                   power_key_inputs: keys, osc32k: osc, cs_pin: cs, mosi_pin: mosi, sclk_pin: sclk, sda_pin: sda};

   host_side_model #(.OSC_HALF(TICK / 2)) u_host_side_model (.clk_i(clk_i), .reset_i(reset_i), .alive_i(alive),
      .sleep_i(hsleep), .spi_i(spi), .osc_o(osc), .keepalive_o(ka), .host_sleep_o(hs), .cs_o(cs));

   power_control_pin_logic #(.GRST_TICKS(GRST), .IRQ_W(16)) u_power_control_pin_logic (.clk_i(clk_i),
      .reset_i(reset_i), .pins_i(pins), .straps_i(straps), .cfg_i(cfg), .irq_event_i(irq_ev),
      .irq_mask_i(irq_mask), .spi_miso_i(miso), .sda_drive_low_i(sda_low), .serial_clk_o(s_clk),
      .serial_cs_o(s_cs), .serial_din_o(s_din), .miso_o(miso_d), .miso_oe_o(miso_oe), .status_o(status),
      .int_o(int_o), .host_slow_clock_out_o(hclk), .peripheral_slow_clock_out_o(pclk),
      .host_reset_out_n_o(hrst_n), .peripheral_reset_out_n_o(prst_n), .charger_disable_o(chg),
      .regs_default_o(def), .usb_switch_close_o(usb_sw));

   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
      if (def === 1'b1)
         def_pulses++;
   always @(posedge pclk)
      pclk_edges++;
   always @(posedge hclk)
      hclk_edges++;

   task automatic chk_bit(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Bounded wait for a state, then one comparison
   task automatic chk_state(input pwr_state_t exp, input int limit);
      int n;
      n = 0;
      @(negedge clk_i);
      while (status.state !== exp && n < limit)
      begin
         @(negedge clk_i);
         n++;
      end
      total_checks++;
      if (status.state !== exp)
      begin
         fails++;
         $display("BAD state expected %0d seen %0d", exp, status.state);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n * TICK) @(posedge clk_i);
   endtask

   task automatic key_hold(input logic [2:0] k, input int n);
      @(posedge clk_i);
      keys <= k;
      ticks(n);
      keys <= 3'b111;
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge clk_i);
      fails++;
      close_out();
   end

   initial
   begin
      {alive, hsleep, psleep, sclk, miso, sda_low} = '0;
      {reset_i, spi, mosi, sda} = 4'hf;
      keys = 3'b111;
      straps = '{startup_profile_strap_a: 1'b1, startup_profile_strap_b: 1'b0, mode_at_digital_core_rail: 1'b1,
                 mode_at_analog_core_rail: 1'b0, id_at_ground: 1'b1, id_at_factory: 1'b0};
      cfg = '0;
      irq_ev = '0;
      irq_mask = '1;
      {fails, total_checks, def_pulses, pclk_edges, hclk_edges} = '0;
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      @(negedge clk_i);
      chk_state(st_off, 0);
      chk_bit("host reset off", 1'b0, hrst_n);
      @(posedge clk_i);
      irq_ev <= 16'h8020;
      repeat (8) @(negedge clk_i);
      chk_bit("int masked", 1'b0, int_o);
      @(posedge clk_i);
      irq_mask <= 16'h7fff;
      repeat (2) @(negedge clk_i);
      chk_bit("int pending", 1'b1, int_o);
      @(posedge clk_i);
      irq_ev <= 16'h0020;
      repeat (2) @(negedge clk_i);
      chk_bit("int cleared", 1'b0, int_o);
      // Both sleep requests already active (low) while starting up
      @(posedge clk_i);
      alive <= 1'b1;
      key_hold(3'b110, 1);
      chk_state(st_start, TICK);
      chk_bit("spi latched", 1'b1, status.bus_is_spi);
      chk_bit("mode lpb", 1'b1, status.op_mode === op_usb_lpb);
      chk_bit("profile a", 1'b1, status.startup_profile[0]);
      chk_bit("profile b", 1'b0, status.startup_profile[1]);
      chk_bit("id grounded", 1'b1, status.id_grounded);
      chk_bit("id floating", 1'b0, status.id_floating);
      chk_bit("id factory", 1'b0, status.id_factory);
      chk_state(st_wdog, 17 * TICK);
      chk_bit("standby ignored", 1'b0, status.standby_event);
      chk_bit("periph clock", 1'b1, pclk_edges > 2);
      chk_state(st_on, 4 * TICK);
      @(negedge clk_i);
      chk_bit("periph reset on", 1'b1, prst_n);
      ticks(1);
      @(negedge clk_i);
      chk_bit("qualify delay", 1'b0, status.standby_event);
      chk_state(st_standby, 4 * TICK);
      @(posedge clk_i);
      psleep <= 1'b1;
      chk_state(st_on, 5 * TICK);
      @(posedge clk_i);
      cfg.peripheral_sleep_pol <= 1'b1;
      chk_state(st_standby, 5 * TICK);
      @(posedge clk_i);
      cfg.host_sleep_pol <= 1'b1;
      chk_state(st_on, 5 * TICK);
      @(posedge clk_i);
      cfg.hold_host_reset <= 1'b1;
      cfg.otg_bus_input_switch <= 1'b1;
      repeat (4) @(negedge clk_i);
      chk_bit("host held", 1'b0, hrst_n);
      chk_bit("periph runs", 1'b1, prst_n);
      chk_bit("usb switch", 1'b1, usb_sw);
      @(posedge clk_i);
      cfg.hold_host_reset <= 1'b0;
      cfg.hold_peripheral_reset <= 1'b1;
      cfg.otg_bus_input_switch <= 1'b0;
      repeat (4) @(negedge clk_i);
      chk_bit("usb switch off", 1'b0, usb_sw);
      chk_bit("periph held", 1'b0, prst_n);
      chk_bit("host runs", 1'b1, hrst_n);
      hclk_edges = 0;
      ticks(3);
      cfg.hold_peripheral_reset <= 1'b0;
      chk_bit("host clock", 1'b1, hclk_edges > 1);
      // Enable bit 0 with the active-low variant means enabled; first a short press
      key_hold(3'b011, GRST / 2);
      ticks(2);
      chk_state(st_on, 0);
      @(posedge clk_i);
      cfg.grst_active_high <= 1'b1;
      key_hold(3'b011, GRST + 4);
      ticks(2);
      chk_state(st_on, 0);
      @(posedge clk_i);
      cfg.grst_active_high <= 1'b0;
      spi <= 1'b0;
      mosi <= 1'b0;
      def_pulses = 0;
      key_hold(3'b011, GRST + 4);
      chk_state(st_grst, 3 * TICK);
      chk_bit("charger off", 1'b1, chg);
      repeat (3) @(negedge clk_i);
      chk_bit("defaults pulse", 1'b1, def_pulses == 1);
      chk_state(st_start, 9 * TICK);
      chk_bit("i2c latched", 1'b0, status.bus_is_spi);
      chk_bit("addr lsb", 1'b0, status.i2c_addr_lsb);
      @(posedge clk_i);
      sclk <= 1'b1;
      sda_low <= 1'b1;
      repeat (8) @(negedge clk_i);
      chk_bit("scl", 1'b1, s_clk);
      chk_bit("sda oe", 1'b1, miso_oe);
      chk_bit("sda low", 1'b0, miso_d);
      chk_bit("sda in", 1'b1, s_din);
      chk_bit("cs unused", 1'b0, s_cs);
      @(posedge clk_i);
      sclk <= 1'b0;
      sda_low <= 1'b0;
      repeat (8) @(negedge clk_i);
      chk_bit("scl low", 1'b0, s_clk);
      chk_bit("sda released", 1'b0, miso_oe);
      chk_state(st_on, 20 * TICK);
      @(posedge clk_i);
      cfg.lp_off_req <= 1'b1;
      chk_state(st_lpoff, 4);
      hclk_edges = 0;
      ticks(3);
      chk_bit("host clock gated", 1'b1, hclk_edges == 0);
      cfg.lpoff_host_clk_on <= 1'b1;
      ticks(3);
      chk_bit("host clock kept", 1'b1, hclk_edges > 1);
      cfg.lp_off_req <= 1'b0;
      key_hold(3'b110, 1);
      chk_state(st_on, 4 * TICK);
      // Keepalive loss with cold start selected, then the watchdog window runs out
      @(posedge clk_i);
      cfg.cold_start_on_wdog <= 1'b1;
      alive <= 1'b0;
      chk_state(st_start, 2 * TICK);
      @(posedge clk_i);
      cfg.cold_start_on_wdog <= 1'b0;
      chk_state(st_off, 82 * TICK);
      chk_bit("host reset", 1'b0, hrst_n);
      close_out();
   end
endmodule
